// [pkg/scdac_regs.svh]
// register map, field positions, fixed bit patterns and codes of the dac control block
// assumes it is included by bare name from the package and the rtl files
//
// Contract
// - sign-magnitude input byte is 00smmmmm, s=1 negative
// - unsigned code: 0 lowest, 62 highest output
// - signed input read as native signed byte
// - unsigned code above 62 treated as signed
// - stalled write holds cpu, applies at phase1
// - inactive column clock keeps cpu gated longer
// - no interrupt recognized while cpu stalled
// - immediate write applies at once, may glitch
// - shutdown sets power off, outputs undriven
// - value register: bit7 one, bit6 zero, code
// - value code resets to mid-scale, analog ground
// - second register reads 0x40 only
// - third register bit7 bus drive, bit5 one
// - fourth register power field, bits5,4 one
// - sync register bit0 arms the stall
// - phase clocks are column clock divided four
// - armed stall catches value write, freezes cpu
// - power codes: off, low, medium, full
`ifndef SCDAC_REGS_SVH
`define SCDAC_REGS_SVH

// ******************************************
// register indices on the cpu register port
// ******************************************
`define SCDAC_IDX_VALUE      3'h0
`define SCDAC_IDX_FIXED1     3'h1
`define SCDAC_IDX_BUSDRV     3'h2
`define SCDAC_IDX_POWER      3'h3
`define SCDAC_IDX_SYNC       3'h4

// ******************************************
// fixed bit patterns and field positions
// ******************************************
`define SCDAC_VALUE_FIXED    8'h80
`define SCDAC_FIXED1_VAL     8'h40
`define SCDAC_BUSDRV_FIXED   8'h20
`define SCDAC_BUSDRV_BIT     7
`define SCDAC_POWER_FIXED    8'h30
`define SCDAC_SYNC_BIT       0
`define SCDAC_SIGN_BIT       5
`define SCDAC_MID_SCALE      6'h00
`define SCDAC_MAG_MAX        8'h1f
`define SCDAC_UCODE_MAX      8'h3e
`define SCDAC_UCODE_MID      8'h1f
`define SCDAC_ZERO8          8'h00

// ******************************************
// phase divider
// ******************************************
`define SCDAC_PH1_SLOT       2'h0
`define SCDAC_PH2_SLOT       2'h2
`define SCDAC_SLOT_STEP      2'h1

`endif

// [pkg/scdac_pkg.sv]
// types shared by the dac control rtl
// assumes the register header sits beside it on the include path
package scdac_pkg;
	`include "scdac_regs.svh"

	// power field codes
	typedef enum logic [1:0] {
		SCDAC_PWR_OFF  = 2'h0,
		SCDAC_PWR_LOW  = 2'h1,
		SCDAC_PWR_MED  = 2'h2,
		SCDAC_PWR_FULL = 2'h3
	} scdac_power_t;

	// input data formats of the driver port
	typedef enum logic [1:0] {
		SCDAC_FMT_UNSIGNED = 2'h0,  // unsigned_code_format
		SCDAC_FMT_SIGNED   = 2'h1,  // signed_native_format
		SCDAC_FMT_SIGNMAG  = 2'h2   // sign_mag_format
	} scdac_fmt_t;

	// write stall states, one-hot
	typedef enum logic [1:0] {
		SCDAC_ST_IDLE  = 2'b01,
		SCDAC_ST_STALL = 2'b10
	} scdac_state_t;
endpackage

// [rtl/scdac_phase_gen.sv]
// phase generator: column clock pin divided by four into two phase levels
// assumes col_clk is asynchronous to clock and much slower than it
`timescale 1ns/100ps
`include "scdac_regs.svh"
module scdac_phase_gen
	import scdac_pkg::*;
(
	input  wire logic clock,       // system clock
	input  wire logic rst_sync_n,  // synchronised reset
	input  wire logic col_clk,     // column clock pin
	output logic      phase1,      // phase 1 level
	output logic      phase2,      // phase 2 level
	output logic      ph1_start    // one-cycle pulse at phase 1 rise
);
	logic       col_s1_r;  // first synchroniser stage
	logic       col_s2_r;  // second synchroniser stage
	logic       col_d_r;   // delayed copy for edge detect
	logic [1:0] slot_r;    // column clock count modulo four
	logic       col_rise;  // rising edge of column clock

	// ******************************************
	// synchroniser and edge detect
	// ******************************************
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			col_s1_r <= 1'b0;
			col_s2_r <= 1'b0;
			col_d_r  <= 1'b0;
		end else begin
			col_s1_r <= col_clk;
			col_s2_r <= col_s1_r;
			col_d_r  <= col_s2_r;
		end
	end

	assign col_rise = col_s2_r & ~col_d_r;

	// divide by four, one update every four column clocks
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			slot_r <= `SCDAC_PH2_SLOT;
		end else if (col_rise) begin
			slot_r <= slot_r + `SCDAC_SLOT_STEP;
		end
	end

	assign phase1    = (slot_r == `SCDAC_PH1_SLOT);
	assign phase2    = (slot_r == `SCDAC_PH2_SLOT);
	assign ph1_start = col_rise & (slot_r == (`SCDAC_PH1_SLOT - `SCDAC_SLOT_STEP));

	// ******************************************
	// checks
	// ******************************************
	property p_phase_apart;
		@(posedge clock) disable iff (!rst_sync_n) !(phase1 && phase2);
	endproperty
	a_phase_apart: assert property (p_phase_apart) else $error("phases overlap");

	property p_ph1_follows;
		@(posedge clock) disable iff (!rst_sync_n) ph1_start |=> phase1;
	endproperty
	a_ph1_follows: assert property (p_ph1_follows) else $error("phase1 missing");
endmodule // scdac_phase_gen

// [rtl/scdac_update_ctrl.sv]
// control of a 6-bit switched-capacitor voltage dac: registers, format
// conversion, immediate and synchronized writes, power and output drive
// assumes the cpu port is on clock and col_clk is a free pin
`timescale 1ns/100ps
`include "scdac_regs.svh"
module scdac_update_ctrl
	import scdac_pkg::*;
(
	input  wire logic       clock,         // 20 mhz system clock
	input  wire logic       rst_n,         // async reset, active low
	input  wire logic       col_clk,       // column clock pin
	input  wire logic [2:0] reg_sel,       // register index
	input  wire logic       reg_wr,        // register write strobe
	input  wire logic       reg_rd,        // register read strobe
	input  wire logic [7:0] reg_wdata,     // register write data
	input  wire logic       drv_wr,        // driver write strobe
	input  wire logic [1:0] drv_fmt,       // driver data format
	input  wire logic [7:0] drv_value,     // driver data byte
	input  wire logic       drv_sync,      // 1 synchronized, 0 immediate
	input  wire logic       shutdown,      // block_shutdown pulse
	output logic [7:0]      reg_rdata,     // read data
	output logic            cpu_stall,     // cpu clock gate request
	output logic            irq_allow,     // interrupts may be taken
	output logic [5:0]      dac_code,      // sign-magnitude code to array
	output logic            dac_drive_en,  // converter output driven
	output logic            bus_drive_en,  // output_bus_drive
	output logic [1:0]      power_level,   // power field to array
	output logic            phase1,        // phase 1 level
	output logic            phase2         // phase 2 level
);
	// ******************************************
	// declarations
	// ******************************************
	logic         rst_s1_r;     // reset release stage one
	logic         rst_sync_n;   // reset release stage two
	logic [5:0]   value_r;      // value field of value register
	logic [5:0]   pend_r;       // value held during a stall
	logic [5:0]   code_r;       // code presented to the array
	logic         busdrv_r;     // bus drive bit
	scdac_power_t power_r;      // power field
	logic         sync_arm_r;   // write stall armed
	logic [7:0]   rdata_r;      // registered read data
	scdac_state_t state_r;      // stall state
	scdac_state_t state_nxt;    // next stall state
	logic         ph1_start;    // phase 1 rising pulse
	logic         val_reg_wr;   // direct write to value register
	logic         any_val_wr;   // any value write
	logic [5:0]   new_val;      // incoming value in sign-magnitude
	logic         want_stall;   // value write that must stall
	logic         take_imm;     // value write applied at once
	logic         release_now;  // stall ends this cycle

	// ******************************************
	// conversion helpers
	// ******************************************
	// signed byte to sign-magnitude with saturating magnitude
	function automatic logic [5:0] sm_of_signed(input logic [7:0] v);
		logic [7:0] mag;
		logic       neg;
		mag = `SCDAC_ZERO8;
		neg = v[7];
		mag = neg ? (`SCDAC_ZERO8 - v) : v;
		if (mag > `SCDAC_MAG_MAX) begin
			mag = `SCDAC_MAG_MAX;
		end
		sm_of_signed = {neg & (mag != `SCDAC_ZERO8), mag[4:0]};
	endfunction

	// driver byte in any format to sign-magnitude
	function automatic logic [5:0] to_sm(input logic [1:0] fmt, input logic [7:0] v);
		logic [7:0] shifted;
		shifted = `SCDAC_ZERO8;
		case (fmt)
			SCDAC_FMT_UNSIGNED: begin
				if (v <= `SCDAC_UCODE_MAX) begin
					shifted = v - `SCDAC_UCODE_MID;
				end else begin
					shifted = v;
				end
				to_sm = sm_of_signed(shifted);
			end
			SCDAC_FMT_SIGNED: begin
				to_sm = sm_of_signed(v);
			end
			SCDAC_FMT_SIGNMAG: begin
				to_sm = v[5:0];
			end
			default: begin
				to_sm = `SCDAC_MID_SCALE;
			end
		endcase
	endfunction

	// ******************************************
	// reset release
	// ******************************************
	// two stages so release is clean on clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_r   <= 1'b1;
			rst_sync_n <= rst_s1_r;
		end
	end

	// ******************************************
	// phase clocks
	// ******************************************
	scdac_phase_gen u_phase (
		.clock      (clock),
		.rst_sync_n (rst_sync_n),
		.col_clk    (col_clk),
		.phase1     (phase1),
		.phase2     (phase2),
		.ph1_start  (ph1_start)
	);

	// ******************************************
	// write decode
	// ******************************************
	// writes are ignored while the cpu is frozen
	assign val_reg_wr  = reg_wr & (reg_sel == `SCDAC_IDX_VALUE) & (state_r == SCDAC_ST_IDLE);
	assign any_val_wr  = val_reg_wr | (drv_wr & (state_r == SCDAC_ST_IDLE));
	assign new_val     = val_reg_wr ? reg_wdata[5:0] : to_sm(drv_fmt, drv_value);
	assign want_stall  = sync_arm_r & (val_reg_wr | (drv_wr & drv_sync & ~val_reg_wr));
	assign take_imm    = any_val_wr & ~want_stall & (state_r == SCDAC_ST_IDLE);
	assign release_now = (state_r == SCDAC_ST_STALL) & ph1_start;

	// ******************************************
	// stall state machine
	// ******************************************
	// next state: stall until phase 1 rises
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SCDAC_ST_IDLE: begin
				if (any_val_wr & want_stall) begin
					state_nxt = SCDAC_ST_STALL;
				end
			end
			SCDAC_ST_STALL: begin
				if (ph1_start) begin
					state_nxt = SCDAC_ST_IDLE;
				end
			end
			default: begin
				state_nxt = SCDAC_ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_r <= SCDAC_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// a stopped column clock simply stretches the stall
	assign cpu_stall = (state_r == SCDAC_ST_STALL);
	assign irq_allow = ~cpu_stall;

	// ******************************************
	// value and pending value
	// ******************************************
	// pending value captured at stall entry
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pend_r <= `SCDAC_MID_SCALE;
		end else if (any_val_wr & want_stall) begin
			pend_r <= new_val;
		end
	end

	// value field of the value register
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			value_r <= `SCDAC_MID_SCALE;
		end else if (release_now) begin
			value_r <= pend_r;
		end else if (take_imm) begin
			value_r <= new_val;
		end
	end

	// array code refreshed each update, or at once on immediate write
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			code_r <= `SCDAC_MID_SCALE;
		end else if (release_now) begin
			code_r <= pend_r;
		end else if (take_imm) begin
			code_r <= new_val;
		end else if (ph1_start) begin
			code_r <= value_r;
		end
	end

	// ******************************************
	// configuration registers
	// ******************************************
	// bus drive bit
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			busdrv_r <= 1'b0;
		end else if (reg_wr & ~cpu_stall & (reg_sel == `SCDAC_IDX_BUSDRV)) begin
			busdrv_r <= reg_wdata[`SCDAC_BUSDRV_BIT];
		end
	end

	// power field, shutdown wins over a write
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			power_r <= SCDAC_PWR_OFF;
		end else if (shutdown) begin
			power_r <= SCDAC_PWR_OFF;
		end else if (reg_wr & ~cpu_stall & (reg_sel == `SCDAC_IDX_POWER)) begin
			power_r <= scdac_power_t'(reg_wdata[1:0]);
		end
	end

	// stall arm bit
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sync_arm_r <= 1'b0;
		end else if (reg_wr & ~cpu_stall & (reg_sel == `SCDAC_IDX_SYNC)) begin
			sync_arm_r <= reg_wdata[`SCDAC_SYNC_BIT];
		end
	end

	// ******************************************
	// read path
	// ******************************************
	// fixed bits read as their required pattern
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rdata_r <= `SCDAC_ZERO8;
		end else if (reg_rd) begin
			case (reg_sel)
				`SCDAC_IDX_VALUE:  rdata_r <= `SCDAC_VALUE_FIXED | {2'h0, value_r};
				`SCDAC_IDX_FIXED1: rdata_r <= `SCDAC_FIXED1_VAL;
				`SCDAC_IDX_BUSDRV: rdata_r <= `SCDAC_BUSDRV_FIXED | {busdrv_r, 7'h00};
				`SCDAC_IDX_POWER:  rdata_r <= `SCDAC_POWER_FIXED | {6'h00, power_r};
				`SCDAC_IDX_SYNC:   rdata_r <= {7'h00, sync_arm_r};
				default:           rdata_r <= `SCDAC_ZERO8;  // unmapped index
			endcase
		end
	end

	// ******************************************
	// outputs
	// ******************************************
	assign reg_rdata    = rdata_r;
	assign dac_code     = code_r;
	assign power_level  = power_r;
	assign dac_drive_en = (power_r != SCDAC_PWR_OFF);
	assign bus_drive_en = busdrv_r & (power_r != SCDAC_PWR_OFF);

	// ******************************************
	// checks
	// ******************************************
	sequence s_stall_entry;
		any_val_wr && want_stall;
	endsequence

	sequence s_release;
		cpu_stall && ph1_start;
	endsequence

	property p_stall_arm;
		@(posedge clock) disable iff (!rst_sync_n) s_stall_entry |=> cpu_stall;
	endproperty
	a_stall_arm: assert property (p_stall_arm) else $error("armed write did not stall");

	property p_stall_hold;
		@(posedge clock) disable iff (!rst_sync_n)
			(cpu_stall && !ph1_start) |=> cpu_stall;
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stall ended early");

	property p_release;
		@(posedge clock) disable iff (!rst_sync_n)
			s_release |=> (!cpu_stall && value_r == $past(pend_r) && code_r == $past(pend_r));
	endproperty
	a_release: assert property (p_release) else $error("stalled value not applied");

	property p_no_irq;
		@(posedge clock) disable iff (!rst_sync_n) cpu_stall |-> !irq_allow;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("interrupt allowed in stall");

	property p_immediate;
		@(posedge clock) disable iff (!rst_sync_n)
			take_imm |=> (code_r == $past(new_val) && !cpu_stall);
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate write late");

	property p_off;
		@(posedge clock) disable iff (!rst_sync_n)
			shutdown |=> (power_r == SCDAC_PWR_OFF && !dac_drive_en && !bus_drive_en);
	endproperty
	a_off: assert property (p_off) else $error("shutdown left outputs driven");

	property p_regen;
		@(posedge clock) disable iff (!rst_sync_n)
			(ph1_start && !cpu_stall && !take_imm) |=> code_r == $past(value_r);
	endproperty
	a_regen: assert property (p_regen) else $error("code not regenerated");

	property p_fixed1;
		@(posedge clock) disable iff (!rst_sync_n)
			(reg_rd && reg_sel == `SCDAC_IDX_FIXED1) |=> reg_rdata == `SCDAC_FIXED1_VAL;
	endproperty
	a_fixed1: assert property (p_fixed1) else $error("fixed register misread");

	property p_value_read;
		@(posedge clock) disable iff (!rst_sync_n)
			(reg_rd && reg_sel == `SCDAC_IDX_VALUE) |=> reg_rdata[7:6] == 2'h2;
	endproperty
	a_value_read: assert property (p_value_read) else $error("value top bits wrong");

	property p_unsigned_top;
		@(posedge clock) disable iff (!rst_sync_n)
			(take_imm && drv_wr && !val_reg_wr && drv_fmt == SCDAC_FMT_UNSIGNED
			 && drv_value == `SCDAC_UCODE_MAX) |=> code_r == 6'h1f;
	endproperty
	a_unsigned_top: assert property (p_unsigned_top) else $error("code 62 not full scale");
endmodule // scdac_update_ctrl

// [tb/scdac_cpu_model.sv]
// cpu model: register and driver writes, frozen while the clock is gated
// assumes the bench calls its tasks; strobes change at falling edges
`timescale 1ns/100ps
module scdac_cpu_model
	import scdac_pkg::*;
(
	input  wire logic       clock,      // system clock
	input  wire logic       cpu_stall,  // cpu clock gate
	input  wire logic [7:0] reg_rdata,  // read data
	output logic [2:0]      reg_sel,    // register index
	output logic            reg_wr,     // write strobe
	output logic            reg_rd,     // read strobe
	output logic [7:0]      reg_wdata,  // write data
	output logic            drv_wr,     // driver strobe
	output logic [1:0]      drv_fmt,    // driver format
	output logic [7:0]      drv_value,  // driver byte
	output logic            drv_sync    // 1 synchronized
);
	// ****************************************
	// idle bus at time zero
	// ****************************************
	initial begin
		{reg_sel, reg_wr, reg_rd, reg_wdata} = 13'h0;
		{drv_wr, drv_fmt, drv_value, drv_sync} = 12'h0;
	end

	// ****************************************
	// bus cycles
	// ****************************************
	// frozen cpu issues nothing; interrupts stay masked by irq_allow of the dut
	task automatic hold();
		int n;
		n = 0;
		while (cpu_stall === 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
	endtask

	// one strobe cycle, data inverted once released
	task automatic cyc(input logic r, input logic w, input logic d, input logic [2:0] s,
		input logic [7:0] x, input logic [1:0] f, input logic y);
		hold();
		@(negedge clock);
		{reg_rd, reg_wr, drv_wr, drv_sync} = {r, w, d, y};
		{reg_sel, reg_wdata, drv_value, drv_fmt} = {s, x, x, f};
		@(negedge clock);
		{reg_rd, reg_wr, drv_wr} = 3'h0;
		reg_wdata = ~reg_wdata;
		drv_value = ~drv_value;
	endtask

	task automatic wr(input logic [2:0] s, input logic [7:0] x);
		cyc(1'b0, 1'b1, 1'b0, s, x, 2'h0, 1'b0);
	endtask

	task automatic rd(input logic [2:0] s, output logic [7:0] q);
		cyc(1'b1, 1'b0, 1'b0, s, 8'h00, 2'h0, 1'b0);
		q = reg_rdata;
	endtask

	task automatic dw(input logic [1:0] f, input logic [7:0] x, input logic y);
		cyc(1'b0, 1'b0, 1'b1, 3'h0, x, f, y);
	endtask
endmodule // scdac_cpu_model

// [tb/scdac_update_ctrl_tb.sv]
// self-checking bench of the dac control block with a cpu model
// assumes package and rtl are compiled first
`timescale 1ns/100ps
module scdac_update_ctrl_tb
	import scdac_pkg::*;
;
	logic       clock;         // 50 ns clock
	logic       rst_n;         // active low reset
	logic       col_clk = 1'b0; // column clock
	logic       col_run;       // column clock enable
	logic       shutdown;      // stop pulse
	logic [2:0] reg_sel;       // cpu side
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic       drv_wr;
	logic [1:0] drv_fmt;
	logic [7:0] drv_value;
	logic       drv_sync;
	logic [7:0] reg_rdata;     // dut side
	logic       cpu_stall;
	logic       irq_allow;
	logic [5:0] dac_code;
	logic       dac_drive_en;
	logic       bus_drive_en;
	logic [1:0] power_level;
	logic       phase1;
	logic       phase2;
	logic [7:0] q;             // read result
	logic [31:0] seed;         // random state
	int         n_mismatch;
	int         tests_run;
	int         i, f, v, n, a, old, ncol;
	int         exp_q[$];      // expected codes
	int         rst_tab[6] = '{8'h80, 8'h40, 8'h20, 8'h30, 8'h00, 8'h00};
	int         edge_v[4] = '{0, 62, 63, 255};

	// ****************************************
	// clocks and instances
	// ****************************************
	initial clock = 1'b0;
	always #25 clock = ~clock;
	// column clock unrelated in phase, may be stopped
	always begin
		#203;
		if (col_run) col_clk = ~col_clk;
	end
	always @(posedge col_clk) ncol++;

	scdac_update_ctrl dut (.clock(clock), .rst_n(rst_n), .col_clk(col_clk),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.drv_wr(drv_wr), .drv_fmt(drv_fmt), .drv_value(drv_value), .drv_sync(drv_sync),
		.shutdown(shutdown), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall),
		.irq_allow(irq_allow), .dac_code(dac_code), .dac_drive_en(dac_drive_en),
		.bus_drive_en(bus_drive_en), .power_level(power_level), .phase1(phase1),
		.phase2(phase2));

	scdac_cpu_model cpu (.clock(clock), .cpu_stall(cpu_stall), .reg_rdata(reg_rdata),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.drv_wr(drv_wr), .drv_fmt(drv_fmt), .drv_value(drv_value), .drv_sync(drv_sync));

	// ****************************************
	// helpers and reference model
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// byte in a format to sign-magnitude code
	function automatic int conv(input int fm, input int x);
		int s;
		int m;
		if (fm == 2) return x & 63;
		s = (fm == 0 && x <= 62) ? x - 31 : (x > 127 ? x - 256 : x);
		m = (s < 0) ? -s : s;
		if (m > 31) m = 31;
		return (s < 0) ? 32 + m : m;
	endfunction

	task automatic chk(input string nm, input logic [7:0] got, input int e);
		tests_run++;
		if (got !== e[7:0]) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e[7:0], got);
		end
	endtask

	// wait for the stall to drop, counting cycles
	task automatic wait_free();
		n = 0;
		while (cpu_stall !== 1'b0 && n < 300) begin
			@(negedge clock);
			n++;
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		end_sim();
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		{rst_n, shutdown, col_run} = {1'b0, 1'b0, 1'b1};
		{n_mismatch, tests_run, seed} = {32'h0, 32'h0, 32'hbbd2};
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
		for (i = 0; i < 6; i++) begin
			cpu.rd(i[2:0], q);
			chk("reset read", q, rst_tab[i]);
		end
		chk("drive off", {dac_drive_en, bus_drive_en, power_level}, 0);
		$display("reset test done");
		cpu.wr(3'h2, 8'hff);
		cpu.rd(3'h2, q);
		chk("bus reg", q, 8'ha0);
		for (i = 0; i < 4; i++) begin
			cpu.wr(3'h3, 8'hcc | i[7:0]);
			cpu.rd(3'h3, q);
			chk("power reg", q, 8'h30 | i);
			chk("power out", {bus_drive_en, dac_drive_en, power_level}, i ? 12 | i : 0);
		end
		$display("power test done");
		for (i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			f = (i < 4) ? 0 : i % 3;
			// sign-magnitude bytes keep their two top bits clear
			v = (i < 4) ? edge_v[i] : (f == 2 ? seed[5:0] : seed[7:0]);
			cpu.dw(f[1:0], v[7:0], 1'b1);
			exp_q.push_back(conv(f, v));
			chk("code", {2'h0, dac_code}, exp_q[0]);
			cpu.rd(3'h0, q);
			chk("value reg", q, 128 | exp_q.pop_front());
		end
		$display("format test done");
		cpu.wr(3'h4, 8'h01);
		cpu.rd(3'h4, q);
		chk("sync reg", q, 1);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			v = seed[5:0];
			old = dac_code;
			if (i == 3) cpu.wr(3'h0, 8'h80 | v[7:0]);
			else cpu.dw(2'h2, v[7:0], 1'b1);
			chk("stalled", {cpu_stall, irq_allow, dac_code}, 128 | old);
			wait_free();
			chk("stall len", n > 0 && n < 40, 1);
			chk("applied", {phase1, 1'b0, dac_code}, 128 | v);
		end
		$display("stall test done");
		col_run = 1'b0;
		repeat (10) @(negedge clock);
		old = dac_code;
		cpu.dw(2'h1, 8'hf0, 1'b1);
		repeat (100) @(negedge clock);
		chk("stopped col", {cpu_stall, dac_code}, 64 | old);
		col_run = 1'b1;
		wait_free();
		chk("restart", {cpu_stall, dac_code}, conv(1, 8'hf0));
		cpu.dw(2'h0, 8'h1f, 1'b0);
		chk("immediate", {cpu_stall, dac_code}, 0);
		$display("column stop test done");
		@(posedge phase1);
		a = ncol;
		@(posedge phase1);
		chk("col per update", ncol - a, 4);
		chk("phases apart", {phase1, phase2}, 2);
		@(negedge clock);
		shutdown = 1'b1;
		@(negedge clock);
		shutdown = 1'b0;
		chk("stop out", {bus_drive_en, dac_drive_en, power_level}, 0);
		cpu.rd(3'h3, q);
		chk("stop reg", q, 8'h30);
		$display("phase and stop test done");
		// second reset in mid-run must bring the code back to mid-scale
		cpu.dw(2'h1, 8'h05, 1'b0);
		chk("pre reset code", {2'h0, dac_code}, conv(1, 5));
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		repeat (3) @(negedge clock);
		cpu.rd(3'h0, q);
		chk("reset value", q, 8'h80);
		chk("reset code", {2'h0, dac_code}, 0);
		cpu.rd(3'h4, q);
		chk("reset sync", q, 0);
		$display("mid reset test done");
		end_sim();
	end
endmodule // scdac_update_ctrl_tb
